/* design/isr_dev_end.sv */
// sensor register bank end: configuration, thresholds and result registers
// Summary of operation
// - upper limit register at 0x01, resets 0x0E
// - host writes upper limit codes 0x00..0x1F only
// - lower limit register at 0x02, resets 0x14
// - host writes lower limit codes 0x20..0x3F only
// - host must load lower limit after power-up
// - power mode set locks registers 0x01..0x05
// - host writes reserved bits as defaults
// - fixed revision byte read at 0x00
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module isr_dev_end #(
	parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	isr_link_if.dev          link,
	input  wire logic        result_valid_in,
	input  wire logic [15:0] proximity_in,
	input  wire logic [23:0] freq_count_in,
	input  wire logic        osc_dead_in,
	input  wire logic        wake_in,
	input  wire logic        comparator_in,
	output logic      [7:0]  impedance_upper_limit_out,
	output logic      [7:0]  impedance_lower_limit_out,
	output logic      [7:0]  sensor_frequency_out,
	output logic      [7:0]  converter_config_out,
	output logic             counter_clock_select_out,
	output logic             counter_clock_powerdown_out,
	output logic      [15:0] threshold_high_out,
	output logic      [15:0] threshold_low_out,
	output logic      [2:0]  interrupt_pin_mode_out,
	output logic             power_mode_bit_out
);
	import isr_pkg::*;

	logic [7:0]  upper;
	logic [7:0]  lower;
	logic [7:0]  freq_set;
	logic [7:0]  conv;
	logic [7:0]  clock_cfg;
	logic [7:0]  thh_buf;
	logic [7:0]  thl_buf;
	logic [15:0] thh;
	logic [15:0] thl;
	logic [7:0]  intp;
	logic [7:0]  power;
	logic [15:0] prox;
	logic [23:0] count;
	logic [3:0]  flags;
	logic        data_pending;
	logic        wr;
	logic        rd;
	logic        locked;
	logic [7:0]  next_rdata;
	logic [7:0]  status_byte;

	assign wr = link.req_valid && link.req_write;
	assign rd = link.req_valid && !link.req_write;

	// while awake the analog front end depends on these, so they are frozen
	assign locked = power[B_POWER_MODE_BIT] && link.req_addr >= A_UPPER && link.req_addr <= A_CLOCK;

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			upper <= R_UPPER;
		else if (wr && !locked && link.req_addr == A_UPPER)
			upper <= link.req_wdata;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			lower <= R_LOWER;
		else if (wr && !locked && link.req_addr == A_LOWER)
			lower <= link.req_wdata;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			freq_set <= R_FREQ;
		else if (wr && !locked && link.req_addr == A_FREQ)
			freq_set <= link.req_wdata;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			conv <= R_CONV;
		else if (wr && !locked && link.req_addr == A_CONV)
			conv <= link.req_wdata & M_CONV;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			clock_cfg <= R_CLOCK;
		else if (wr && !locked && link.req_addr == A_CLOCK)
			clock_cfg <= link.req_wdata & M_CLOCK;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			intp  <= R_INTP;
			power <= R_POWER;
		end else if (wr && link.req_addr == A_INTP) begin
			intp <= link.req_wdata & M_INTP;
		end else if (wr && link.req_addr == A_POWER) begin
			power <= link.req_wdata & M_POWER;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// thresholds: low byte is staged, high byte write commits both halves
	// so the comparator never sees a half-updated value

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			thh_buf <= R_THH;
			thh     <= {R_THH, R_THH};
		end else if (wr && link.req_addr == A_THH_L) begin
			thh_buf <= link.req_wdata;
		end else if (wr && link.req_addr == A_THH_H) begin
			thh <= {link.req_wdata, thh_buf};
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			thl_buf <= R_THL;
			thl     <= {R_THL, R_THL};
		end else if (wr && link.req_addr == A_THL_L) begin
			thl_buf <= link.req_wdata;
		end else if (wr && link.req_addr == A_THL_H) begin
			thl <= {link.req_wdata, thl_buf};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion results; the link never writes these

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prox  <= '0;
			count <= '0;
			flags <= '0;
		end else if (result_valid_in) begin
			prox  <= proximity_in;
			count <= freq_count_in;
			flags <= {osc_dead_in, 1'b0, wake_in, comparator_in};
		end
	end

	// new data stays flagged until the proximity low byte is read;
	// a result arriving in that same cycle keeps the flag up
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			data_pending <= 1'b0;
		else if (result_valid_in)
			data_pending <= 1'b1;
		else if (rd && link.req_addr == A_PRX_L)
			data_pending <= 1'b0;
	end

	always_comb begin
		status_byte            = ZERO8;
		status_byte[B_ST_OSC]  = flags[3];
		status_byte[B_ST_DRDY] = !data_pending;
		status_byte[B_ST_WAKE] = flags[1];
		status_byte[B_ST_CMP]  = flags[0];
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	always_comb begin
		if (link.req_addr == A_REV)
			next_rdata = REVISION;
		else if (link.req_addr == A_UPPER)
			next_rdata = upper;
		else if (link.req_addr == A_LOWER)
			next_rdata = lower;
		else if (link.req_addr == A_FREQ)
			next_rdata = freq_set;
		else if (link.req_addr == A_CONV)
			next_rdata = conv;
		else if (link.req_addr == A_CLOCK)
			next_rdata = clock_cfg;
		else if (link.req_addr == A_THH_L)
			next_rdata = thh[7:0];
		else if (link.req_addr == A_THH_H)
			next_rdata = thh[15:8];
		else if (link.req_addr == A_THL_L)
			next_rdata = thl[7:0];
		else if (link.req_addr == A_THL_H)
			next_rdata = thl[15:8];
		else if (link.req_addr == A_INTP)
			next_rdata = intp;
		else if (link.req_addr == A_POWER)
			next_rdata = power;
		else if (link.req_addr == A_STAT)
			next_rdata = status_byte;
		else if (link.req_addr == A_PRX_L)
			next_rdata = prox[7:0];
		else if (link.req_addr == A_PRX_H)
			next_rdata = prox[15:8];
		else if (link.req_addr == A_CNT_L)
			next_rdata = count[7:0];
		else if (link.req_addr == A_CNT_M)
			next_rdata = count[15:8];
		else if (link.req_addr == A_CNT_H)
			next_rdata = count[23:16];
		else
			next_rdata = ZERO8;
	end

	// every request, read or write, is answered in the following cycle
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.rsp_valid <= 1'b0;
			link.rsp_rdata <= ZERO8;
		end else begin
			link.rsp_valid <= link.req_valid;
			link.rsp_rdata <= rd ? next_rdata : ZERO8;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			link.interrupt_pin_n <= 1'b1;
		else
			link.interrupt_pin_n <= !(data_pending && intp[2:0] == INT_MODE_DRDY);
	end

	////////////////////////////////////////////////////////////////////////
	// user-side configuration outputs

	assign impedance_upper_limit_out   = upper;
	assign impedance_lower_limit_out   = lower;
	assign sensor_frequency_out        = freq_set;
	assign converter_config_out        = conv;
	assign counter_clock_select_out    = clock_cfg[B_CLK_SEL];
	assign counter_clock_powerdown_out = clock_cfg[B_COUNTER_CLOCK_POWERDOWN];
	assign threshold_high_out          = thh;
	assign threshold_low_out           = thl;
	assign interrupt_pin_mode_out      = intp[2:0];
	assign power_mode_bit_out          = power[B_POWER_MODE_BIT];
endmodule

/* pkg/isr_pkg.sv */
// shared constants for the inductive sensor register bank and its controller
package isr_pkg;
	localparam int AW = 8;
	localparam int DW = 8;
	// device register offsets
	localparam logic [7:0] A_REV   = 8'h00;
	localparam logic [7:0] A_UPPER = 8'h01;
	localparam logic [7:0] A_LOWER = 8'h02;
	localparam logic [7:0] A_FREQ  = 8'h03;
	localparam logic [7:0] A_CONV  = 8'h04;
	localparam logic [7:0] A_CLOCK = 8'h05;
	localparam logic [7:0] A_THH_L = 8'h06;
	localparam logic [7:0] A_THH_H = 8'h07;
	localparam logic [7:0] A_THL_L = 8'h08;
	localparam logic [7:0] A_THL_H = 8'h09;
	localparam logic [7:0] A_INTP  = 8'h0A;
	localparam logic [7:0] A_POWER = 8'h0B;
	localparam logic [7:0] A_STAT  = 8'h20;
	localparam logic [7:0] A_PRX_L = 8'h21;
	localparam logic [7:0] A_PRX_H = 8'h22;
	localparam logic [7:0] A_CNT_L = 8'h23;
	localparam logic [7:0] A_CNT_M = 8'h24;
	localparam logic [7:0] A_CNT_H = 8'h25;
	// reset values
	localparam logic [7:0] R_UPPER = 8'h0E;
	localparam logic [7:0] R_LOWER = 8'h14;
	localparam logic [7:0] R_FREQ  = 8'h45;
	localparam logic [7:0] R_CONV  = 8'h1B;
	localparam logic [7:0] R_CLOCK = 8'h01;
	localparam logic [7:0] R_THH   = 8'hFF;
	localparam logic [7:0] R_THL   = 8'h00;
	localparam logic [7:0] R_INTP  = 8'h00;
	localparam logic [7:0] R_POWER = 8'h00;
	localparam logic [7:0] ZERO8   = 8'h00;
	// writable bits; reserved bits stay at their zero default
	localparam logic [7:0] M_CONV  = 8'h1F;
	localparam logic [7:0] M_CLOCK = 8'h03;
	localparam logic [7:0] M_INTP  = 8'h07;
	localparam logic [7:0] M_POWER = 8'h01;
	localparam logic [7:0] M_ALL   = 8'hFF;
	// legal code windows for the impedance limits
	localparam logic [7:0] UPPER_MIN = 8'h00;
	localparam logic [7:0] UPPER_MAX = 8'h1F;
	localparam logic [7:0] LOWER_MIN = 8'h20;
	localparam logic [7:0] LOWER_MAX = 8'h3F;
	// field positions
	localparam int B_POWER_MODE_BIT = 0;
	localparam int B_COUNTER_CLOCK_POWERDOWN   = 0;
	localparam int B_CLK_SEL  = 1;
	localparam int B_ST_OSC   = 7;
	localparam int B_ST_DRDY  = 6;
	localparam int B_ST_WAKE  = 5;
	localparam int B_ST_CMP   = 4;
	localparam logic [2:0] INT_MODE_DRDY = 3'h4;
	// controller register offsets
	localparam logic [3:0] H_ADDR = 4'h0;
	localparam logic [3:0] H_CMD  = 4'h1;
	localparam logic [3:0] H_STAT = 4'h2;
	localparam logic [3:0] H_IRQ  = 4'h3;
	localparam logic [3:0] H_MASK = 4'h4;
	localparam int B_CMD_WRITE = 8;
	localparam int NEV     = 3;
	localparam int EV_DONE = 0;
	localparam int EV_REF  = 1;
	localparam int EV_PIN  = 2;
	typedef enum logic [1:0] {ISR_IDLE, ISR_REQ, ISR_WAIT} isr_state_t;
endpackage

/* pkg/isr_link_if.sv */
// register access link between controller and sensor register bank
`timescale 1ns/1ns
interface isr_link_if;
	logic                    req_valid;
	logic                    req_write;
	logic [isr_pkg::AW-1:0]  req_addr;
	logic [isr_pkg::DW-1:0]  req_wdata;
	logic                    rsp_valid;
	logic [isr_pkg::DW-1:0]  rsp_rdata;
	logic                    interrupt_pin_n;
	modport dev  (input req_valid, req_write, req_addr, req_wdata, output rsp_valid, rsp_rdata, interrupt_pin_n);
	modport host (output req_valid, req_write, req_addr, req_wdata, input rsp_valid, rsp_rdata, interrupt_pin_n);
endinterface

/* design/isr_evt_reg.sv */
// sticky event bits with write-one-to-clear and mask onto one interrupt
`timescale 1ns/1ns
module isr_evt_reg (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic [isr_pkg::NEV-1:0] event_in,
	input  wire logic                 clear_we_in,
	input  wire logic                 mask_we_in,
	input  wire logic [isr_pkg::NEV-1:0] wdata_in,
	output logic      [isr_pkg::NEV-1:0] status_out,
	output logic      [isr_pkg::NEV-1:0] mask_out,
	output logic                      irq_out
);
	import isr_pkg::*;

	genvar i;
	generate
		for (i = 0; i < NEV; i++) begin : g_bit
			// a new event in the clearing cycle is kept
			always_ff @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in)
					status_out[i] <= 1'b0;
				else if (event_in[i])
					status_out[i] <= 1'b1;
				else if (clear_we_in && wdata_in[i])
					status_out[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			mask_out <= '0;
		else if (mask_we_in)
			mask_out <= wdata_in;
	end

	assign irq_out = |(status_out & mask_out);
endmodule

/* design/isr_host_end.sv */
// controller end: issues register accesses on the link for software
`timescale 1ns/1ns
module isr_host_end (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	isr_link_if.host         link,
	input  wire logic [3:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out,
	output logic             irq_out
);
	import isr_pkg::*;

	isr_state_t            state;
	logic [AW-1:0]         target;
	logic [DW-1:0]         last_rdata;
	logic                  lower_written;
	logic                  pin_q;
	logic                  launch;
	logic                  legal;
	logic [DW-1:0]         wmask;
	logic [NEV-1:0]        ev;
	logic [NEV-1:0]        ev_status;
	logic [NEV-1:0]        ev_mask;
	logic                  cmd_wr;

	assign cmd_wr = wr_in && addr_in == H_CMD;

	// impedance limits only take codes from their tables
	always_comb begin
		legal = 1'b1;
		if (target == A_UPPER)
			legal = wdata_in[7:0] >= UPPER_MIN && wdata_in[7:0] <= UPPER_MAX;
		else if (target == A_LOWER)
			legal = wdata_in[7:0] >= LOWER_MIN && wdata_in[7:0] <= LOWER_MAX;
	end

	// reserved bits always go out as zero
	always_comb begin
		if (target == A_CONV)
			wmask = M_CONV;
		else if (target == A_CLOCK)
			wmask = M_CLOCK;
		else if (target == A_INTP)
			wmask = M_INTP;
		else if (target == A_POWER)
			wmask = M_POWER;
		else
			wmask = M_ALL;
	end

	assign launch = cmd_wr && state == ISR_IDLE && (!wdata_in[B_CMD_WRITE] || legal);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state          <= ISR_IDLE;
			link.req_valid <= 1'b0;
			link.req_write <= 1'b0;
			link.req_addr  <= ZERO8;
			link.req_wdata <= ZERO8;
		end else begin
			link.req_valid <= 1'b0;
			case (state)
				ISR_IDLE: begin
					if (launch) begin
						state          <= ISR_REQ;
						link.req_valid <= 1'b1;
						link.req_write <= wdata_in[B_CMD_WRITE];
						link.req_addr  <= target;
						link.req_wdata <= wdata_in[7:0] & wmask;
					end
				end
				ISR_REQ: state <= ISR_WAIT;
				ISR_WAIT: if (link.rsp_valid) state <= ISR_IDLE;
				default: state <= ISR_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			target <= ZERO8;
		else if (wr_in && addr_in == H_ADDR)
			target <= wdata_in[7:0];
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			last_rdata <= ZERO8;
		else if (state == ISR_WAIT && link.rsp_valid)
			last_rdata <= link.rsp_rdata;
	end

	// readings are untrustworthy until the lower limit is loaded after reset
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			lower_written <= 1'b0;
		else if (launch && wdata_in[B_CMD_WRITE] && target == A_LOWER)
			lower_written <= 1'b1;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			pin_q <= 1'b1;
		else
			pin_q <= link.interrupt_pin_n;
	end

	assign ev[EV_DONE] = state == ISR_WAIT && link.rsp_valid;
	assign ev[EV_REF]  = cmd_wr && !launch;
	assign ev[EV_PIN]  = pin_q && !link.interrupt_pin_n;

	isr_evt_reg u_evt (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.event_in    (ev),
		.clear_we_in (wr_in && addr_in == H_IRQ),
		.mask_we_in  (wr_in && addr_in == H_MASK),
		.wdata_in    (wdata_in[NEV-1:0]),
		.status_out  (ev_status),
		.mask_out    (ev_mask),
		.irq_out     (irq_out)
	);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			rdata_out <= '0;
		else if (!rd_in)
			rdata_out <= '0;
		else if (addr_in == H_ADDR)
			rdata_out <= {8'h00, target};
		else if (addr_in == H_STAT)
			rdata_out <= {6'h00, state != ISR_IDLE, lower_written, last_rdata};
		else if (addr_in == H_IRQ)
			rdata_out <= {13'h0000, ev_status};
		else if (addr_in == H_MASK)
			rdata_out <= {13'h0000, ev_mask};
		else
			rdata_out <= '0;
	end
endmodule

/* tb/isr_link_chk.sv */
// concurrent checks on the register access link between the two ends
`timescale 1ns/1ns
module isr_link_chk #(
	parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
	input  wire logic                   core_clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   req_valid,
	input  wire logic                   req_write,
	input  wire logic [isr_pkg::AW-1:0] req_addr,
	input  wire logic [isr_pkg::DW-1:0] req_wdata,
	input  wire logic                   rsp_valid,
	input  wire logic [isr_pkg::DW-1:0] rsp_rdata,
	input  wire logic                   interrupt_pin_n
);
	import isr_pkg::*;

	logic       pwr_q;
	logic [7:0] upper_q;
	logic [2:0] mode_q;
	wire        wr = req_valid && req_write;
	wire        rd = req_valid && !req_write;

	////////////////////////////////////////////////////////////////
	// shadow of the lock bit and upper limit, so read-back can be judged
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwr_q <= 1'b0;
		end else if (wr && req_addr == A_POWER) begin
			pwr_q <= req_wdata[B_POWER_MODE_BIT];
		end
	end
	// shadow of the pin mode; the pin lags a mode write by one cycle
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q <= R_INTP[2:0];
		end else if (wr && req_addr == A_INTP) begin
			mode_q <= req_wdata[2:0];
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			upper_q <= R_UPPER;
		end else if (wr && req_addr == A_UPPER && !pwr_q) begin
			upper_q <= req_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_rsp_follows: assert property (req_valid |=> rsp_valid)
		else $error("no response one cycle after a request");
	chk_rsp_caused: assert property (rsp_valid |-> $past(req_valid))
		else $error("response without a request");
	chk_one_at_time: assert property (req_valid |=> !req_valid [*2])
		else $error("requests issued closer than one at a time");
	chk_upper_code: assert property (wr && req_addr == A_UPPER |-> req_wdata <= UPPER_MAX)
		else $error("upper limit written with an illegal code");
	chk_lower_code: assert property (wr && req_addr == A_LOWER |-> req_wdata inside {[LOWER_MIN:LOWER_MAX]})
		else $error("lower limit written with an illegal code");
	chk_conv_reserved: assert property (wr && req_addr == A_CONV |-> (req_wdata & ~M_CONV) == ZERO8)
		else $error("reserved converter bits written non-zero");
	chk_power_reserved: assert property (wr && req_addr == A_POWER |-> (req_wdata & ~M_POWER) == ZERO8)
		else $error("reserved power bits written non-zero");
	chk_rev_read: assert property (rd && req_addr == A_REV |=> rsp_valid && rsp_rdata == REVISION)
		else $error("revision read returned a wrong value");
	chk_upper_lock: assert property (rd && req_addr == A_UPPER |=> rsp_rdata == upper_q)
		else $error("upper limit read-back differs from expected");
	chk_write_quiet: assert property (wr |=> rsp_rdata == ZERO8)
		else $error("write response carried data");
	chk_status_pad: assert property (rd && req_addr == A_STAT |=> rsp_rdata[3:0] == 4'h0)
		else $error("status padding bits not zero");
	chk_pin_mode: assert property (!interrupt_pin_n |-> $past(mode_q) == INT_MODE_DRDY)
		else $error("interrupt pin low outside data-ready mode");
endmodule

/* tb/inductive_sensor_register_bank_test.sv */
// self-checking bench: software port of the controller driving the register bank
`timescale 1ns/1ns
module inductive_sensor_register_bank_test;
	import isr_pkg::*;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	localparam logic [1:0] OK  = 2'b01;
	localparam logic [1:0] REF = 2'b10;
	logic        core_clk_in, rst_n_in, wr_in, rd_in, irq_out, pwr_out;
	logic        result_valid_in, osc_dead_in, wake_in, comparator_in;
	logic [3:0]  addr_in;
	logic [15:0] wdata_in, rdata_out, proximity_in, thh_out, thl_out, s;
	logic [23:0] freq_count_in;
	logic [7:0]  conv_out, up_out, lo_out, fq_out;
	logic [2:0]  mode_out;
	logic        csel_out, cpd_out;
	logic [7:0]  rst_v [5] = '{R_UPPER, R_LOWER, R_FREQ, R_CONV, R_CLOCK};
	logic [7:0]  set_a [5] = '{8'h05, 8'h22, 8'h77, 8'h0A, 8'h02};
	logic [7:0]  set_b [5] = '{8'h1F, 8'h3F, 8'h11, 8'h12, 8'h00};
	logic [7:0]  res_v [5] = '{8'hEF, 8'hBE, 8'h56, 8'h34, 8'h12};
	int          failures, n_compared;

	isr_link_if isr_link_if_i ();
	isr_host_end isr_host_end_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(isr_link_if_i),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
	isr_dev_end #(.REVISION(REV)) isr_dev_end_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(isr_link_if_i),
		.result_valid_in(result_valid_in), .proximity_in(proximity_in), .freq_count_in(freq_count_in),
		.osc_dead_in(osc_dead_in), .wake_in(wake_in), .comparator_in(comparator_in),
		.impedance_upper_limit_out(up_out), .impedance_lower_limit_out(lo_out), .sensor_frequency_out(fq_out),
		.converter_config_out(conv_out), .counter_clock_select_out(csel_out), .counter_clock_powerdown_out(cpd_out),
		.threshold_high_out(thh_out), .threshold_low_out(thl_out), .interrupt_pin_mode_out(mode_out),
		.power_mode_bit_out(pwr_out));
	isr_link_chk #(.REVISION(REV)) isr_link_chk_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.req_valid(isr_link_if_i.req_valid), .req_write(isr_link_if_i.req_write), .req_addr(isr_link_if_i.req_addr),
		.req_wdata(isr_link_if_i.req_wdata), .rsp_valid(isr_link_if_i.rsp_valid), .rsp_rdata(isr_link_if_i.rsp_rdata),
		.interrupt_pin_n(isr_link_if_i.interrupt_pin_n));

	always #5 core_clk_in = ~core_clk_in;

	////////////////////////////////////////////////////////////////
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// every user-side output except conv_out against its reset value
	task chk_defaults;
		cmp({up_out, lo_out}, {R_UPPER, R_LOWER});
		cmp({fq_out, 4'h0, pwr_out, mode_out}, {R_FREQ, 4'h0, R_POWER[0], R_INTP[2:0]});
		cmp({14'h0000, csel_out, cpd_out}, {14'h0000, R_CLOCK[1:0]});
		cmp(thh_out, {R_THH, R_THH});
		cmp(thl_out, {R_THL, R_THL});
	endtask
	task tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task hwr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	task hrd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask
	// one link transfer; the outcome is read from the sticky done/refused bits, which are then cleared
	task op(input logic [7:0] tgt, input logic w, input logic [7:0] d, output logic [1:0] ev);
		logic [15:0] r;
		hwr(H_ADDR, {8'h00, tgt});
		hwr(H_CMD, {7'h00, w, d});
		ev = 2'b00;
		for (int i = 0; i < 10 && ev == 2'b00; i++) begin
			hrd(H_IRQ, r);
			ev = r[1:0];
		end
		if (ev == 2'b00) begin
			failures++;
			$display("ERROR at %0t: link transfer never finished", $time);
			tally_and_finish();
		end
		hwr(H_IRQ, {14'h0000, ev});
	endtask
	task dwr(input logic [7:0] tgt, input logic [7:0] d, input logic [1:0] exp_ev);
		logic [1:0] ev;
		op(tgt, 1'b1, d, ev);
		cmp({14'h0000, ev}, {14'h0000, exp_ev});
	endtask
	task dchk(input logic [7:0] tgt, input logic [7:0] exp);
		logic [1:0]  ev;
		logic [15:0] r;
		op(tgt, 1'b0, 8'h00, ev);
		hrd(H_STAT, r);
		cmp({8'h00, r[7:0]}, {8'h00, exp});
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		core_clk_in = 1'b0;
		rst_n_in = 1'b0;
		{wr_in, rd_in, addr_in, wdata_in} = '0;
		{result_valid_in, proximity_in, freq_count_in, osc_dead_in, wake_in, comparator_in} = '0;
		failures = 0;
		n_compared = 0;
		repeat (10) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 5; i++) dchk(A_UPPER + 8'(i), rst_v[i]);
		chk_defaults();
		dchk(A_REV, REV);
		dwr(A_REV, 8'h00, OK);
		dchk(A_REV, REV);
		dchk(8'h30, 8'h00);
		// out-of-window codes never reach the bank
		dwr(A_UPPER, 8'h20, REF);
		dwr(A_LOWER, 8'h1F, REF);
		dwr(A_LOWER, 8'h40, REF);
		dchk(A_LOWER, R_LOWER);
		hrd(H_STAT, s);
		cmp({15'h0000, s[8]}, 16'h0000);
		for (int i = 0; i < 5; i++) dwr(A_UPPER + 8'(i), set_a[i], OK);
		for (int i = 0; i < 5; i++) dchk(A_UPPER + 8'(i), set_a[i]);
		cmp({up_out, lo_out}, {set_a[0], set_a[1]});
		hrd(H_STAT, s);
		cmp({15'h0000, s[8]}, 16'h0001);
		// locked: writes are acknowledged but must not land
		dwr(A_POWER, 8'h01, OK);
		cmp({15'h0000, pwr_out}, 16'h0001);
		for (int i = 0; i < 5; i++) dwr(A_UPPER + 8'(i), set_b[i], OK);
		for (int i = 0; i < 5; i++) dchk(A_UPPER + 8'(i), set_a[i]);
		cmp({up_out, lo_out}, {set_a[0], set_a[1]});
		dwr(A_POWER, 8'h00, OK);
		cmp({15'h0000, pwr_out}, 16'h0000);
		for (int i = 0; i < 5; i++) dwr(A_UPPER + 8'(i), set_b[i], OK);
		for (int i = 0; i < 5; i++) dchk(A_UPPER + 8'(i), set_b[i]);
		cmp({up_out, lo_out}, {set_b[0], set_b[1]});
		cmp({14'h0000, csel_out, cpd_out}, {14'h0000, set_b[4][1:0]});
		dwr(A_CONV, 8'hFF, OK);
		dchk(A_CONV, M_CONV);
		cmp({8'h00, conv_out}, {8'h00, M_CONV});
		dwr(A_THH_L, 8'h34, OK);
		cmp(thh_out, 16'hFFFF);
		dwr(A_THH_H, 8'h12, OK);
		cmp(thh_out, 16'h1234);
		dwr(A_THL_L, 8'h78, OK);
		cmp(thl_out, 16'h0000);
		dwr(A_THL_H, 8'h56, OK);
		cmp(thl_out, 16'h5678);
		// fresh result: pin falls, results readable, writes to them ignored
		dwr(A_INTP, {5'h00, INT_MODE_DRDY}, OK);
		cmp({13'h0000, mode_out}, {13'h0000, INT_MODE_DRDY});
		hwr(H_MASK, 16'h0004);
		hrd(H_MASK, s);
		cmp(s, 16'h0004);
		@(posedge core_clk_in);
		proximity_in    <= 16'hBEEF;
		freq_count_in   <= 24'h12_3456;
		osc_dead_in     <= 1'b1;
		comparator_in   <= 1'b1;
		wake_in         <= 1'b1;
		result_valid_in <= 1'b1;
		@(posedge core_clk_in);
		result_valid_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		#1;
		cmp({15'h0000, isr_link_if_i.interrupt_pin_n}, 16'h0000);
		cmp({15'h0000, irq_out}, 16'h0001);
		dchk(A_STAT, 8'hB0);
		for (int i = 0; i < 5; i++) dchk(A_PRX_L + 8'(i), res_v[i]);
		dchk(A_STAT, 8'hF0);
		cmp({15'h0000, isr_link_if_i.interrupt_pin_n}, 16'h0001);
		hwr(H_IRQ, 16'h0004);
		#1;
		cmp({15'h0000, irq_out}, 16'h0000);
		dwr(A_PRX_L, 8'h00, OK);
		dchk(A_PRX_L, 8'hEF);
		// done event raised when unmasked, silent when masked
		for (int m = 1; m >= 0; m--) begin
			hwr(H_MASK, {15'h0000, 1'(m)});
			hwr(H_CMD, 16'h0000);
			repeat (6) @(posedge core_clk_in);
			#1;
			cmp({15'h0000, irq_out}, {15'h0000, 1'(m)});
			hwr(H_IRQ, 16'h0001);
			#1;
			cmp({15'h0000, irq_out}, 16'h0000);
		end
		// busy shows while a transfer runs; a command in that time is refused
		hwr(H_CMD, 16'h0000);
		hrd(H_STAT, s);
		cmp({15'h0000, s[9]}, 16'h0001);
		repeat (4) @(posedge core_clk_in);
		hwr(H_CMD, 16'h0000);
		hwr(H_CMD, 16'h0000);
		repeat (4) @(posedge core_clk_in);
		hrd(H_IRQ, s);
		cmp({14'h0000, s[1:0]}, {14'h0000, REF | OK});
		hwr(H_IRQ, 16'h0003);
		hrd(H_ADDR, s);
		cmp(s, {8'h00, A_PRX_L});
		hrd(4'hF, s);
		cmp(s, 16'h0000);
		// a reset in mid-run brings every register back to its default
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		chk_defaults();
		hrd(H_STAT, s);
		cmp(s, 16'h0000);
		dchk(A_UPPER, R_UPPER);
		tally_and_finish();
	end
endmodule
